// >>> hdl/sdt_pkg.sv
package sdt_pkg;

	// clock and logic-cycle timing
	localparam int unsigned CLK_HZ           = 10_000_000;         // pclk rate
	localparam int unsigned LOGIC_CYCLE_MS   = 4;                  // logic execution cycle time in ms
	localparam int unsigned LOGIC_CYCLE_CLKS = LOGIC_CYCLE_MS * (CLK_HZ / 1000);

	// quiet interval limits, held in 10 ms steps
	localparam int unsigned QUIET_STEP_MS  = 10;                    // granularity of the quiet interval
	localparam logic [9:0]  QUIET_MIN_STEP = 10'h00A;               // 100 ms
	localparam logic [9:0]  QUIET_MAX_STEP = 10'h3E8;               // 10 s
	localparam logic [9:0]  QUIET_RST_STEP = 10'h00A;               // reset value: 100 ms

	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;                    // configuration
	localparam logic [7:0] OFS_QUIET    = 8'h04;                    // quiet interval steps
	localparam logic [7:0] OFS_STATUS   = 8'h08;                    // live state
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;                    // sticky events, read only
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;                    // write one to clear
	localparam logic [7:0] OFS_IRQ_EN   = 8'h14;                    // interrupt enables

	// control field positions and reset value
	localparam int unsigned CTRL_CFG_LSB   = 0;                     // encoder configuration, 2 bits
	localparam int unsigned CTRL_PLAUS_BIT = 2;                     // plausibility check enable
	localparam int unsigned CTRL_FOUT_BIT  = 3;                     // fault outputs present
	localparam logic [3:0]  CTRL_RST       = 4'h0;

	// status field positions
	localparam int unsigned ST_STILL_BIT = 0;
	localparam int unsigned ST_F1_BIT    = 1;
	localparam int unsigned ST_F2_BIT    = 2;
	localparam int unsigned ST_GRP_BIT   = 3;
	localparam int unsigned ST_EVAL_BIT  = 4;

	// event bits: standstill reached, pair 1 fault, pair 2 fault
	localparam int unsigned IRQ_W = 3;

	// synchroniser depth for pin inputs
	localparam int unsigned SYNC_STAGES = 3;

	// encoder input configuration
	typedef enum logic [1:0] {
		SDT_CFG_SINGLE = 2'h0,
		SDT_CFG_ONE    = 2'h1,
		SDT_CFG_TWO    = 2'h2
	} sdt_cfg_t;

	// evaluation states, one-hot
	typedef enum logic [2:0] {
		SDT_IDLE  = 3'h1,
		SDT_EVAL  = 3'h2,
		SDT_STILL = 3'h4
	} sdt_state_t;

endpackage : sdt_pkg

// >>> hdl/sdt_smp_if.sv
// sampled inputs and the logic-cycle tick passed into the core
interface sdt_smp_if;
	logic       permit;     // synchronised motion permit
	logic [3:0] trk;        // synchronised encoder tracks
	logic       tick;       // one-cycle pulse per logic cycle

	modport sync_src (output permit, output trk);
	modport tick_src (output tick);
	modport core     (input permit, input trk, input tick);
endinterface : sdt_smp_if

// >>> hdl/sdt_sync.sv
// three-stage synchroniser; output follows once stages two and three agree
module sdt_sync
	import sdt_pkg::*;
#(
	parameter int unsigned W = 5
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// raw pins
	input  wire logic [W-1:0] pin_in,
	// filtered value
	output logic      [W-1:0] val_o
);
	logic [W-1:0] st_reg [SYNC_STAGES];     // synchroniser chain
	logic [W-1:0] val_reg;                  // accepted value
	logic [W-1:0] val_next;

	// accept a change only when the last two stages agree
	always_comb begin
		val_next = val_reg;
		for (int i = 0; i < W; i++) begin
			if (st_reg[1][i] == st_reg[2][i]) begin
				val_next[i] = st_reg[2][i];
			end
		end
	end

	// chain and accepted value; first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 0; s < SYNC_STAGES; s++) begin
				st_reg[s] <= '0;
			end
			val_reg <= '0;
		end else begin
			st_reg[0] <= pin_in;
			for (int s = 1; s < SYNC_STAGES; s++) begin
				st_reg[s] <= st_reg[s-1];
			end
			val_reg <= val_next;
		end
	end

	assign val_o = val_reg;
endmodule : sdt_sync

// >>> hdl/sdt_tick.sv
// divider giving one enable pulse per logic cycle
module sdt_tick #(
	parameter int unsigned DIV = 40000
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pulse out
	sdt_smp_if.tick_src tk
);
	localparam int unsigned CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_reg;                 // cycles since last tick
	logic [CW-1:0] cnt_next;
	logic          tick_reg;
	logic          tick_next;

	// count to DIV-1 then wrap and pulse
	always_comb begin
		tick_next = (cnt_reg == CW'(DIV - 1));
		cnt_next  = tick_next ? '0 : cnt_reg + CW'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tk.tick = tick_reg;
endmodule : sdt_tick

// >>> hdl/sdt_top.sv
module sdt_top
	import sdt_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = LOGIC_CYCLE_CLKS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// machine pins
	input  wire logic        motion_permit,
	input  wire logic [3:0]  enc_trk,
	// results
	output logic             standstill,
	output logic             pair1_fault,
	output logic             pair2_fault,
	output logic             group_fault,
	output logic             irq
);
	import sdt_pkg::*;

	sdt_smp_if smp ();                      // sampled pins and tick

	// pins pass the three-stage synchroniser
	sdt_sync #(.W(5)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({motion_permit, enc_trk}),
		.val_o   ({smp.permit, smp.trk})
	);

	// logic-cycle enable
	sdt_tick #(.DIV(CYCLE_CLKS)) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (smp)
	);

	// tracks watched in each encoder configuration
	function automatic logic [3:0] trk_mask(input logic [1:0] cfg);
		case (cfg)
			SDT_CFG_SINGLE: trk_mask = 4'h1;
			SDT_CFG_ONE:    trk_mask = 4'h3;
			SDT_CFG_TWO:    trk_mask = 4'hF;
			default:        trk_mask = 4'h1;  // reserved code behaves as single track
		endcase
	endfunction : trk_mask

	// address decode shared by read and write paths
	function automatic logic is_reg(input logic [7:0] a);
		is_reg = (a == OFS_CTRL) || (a == OFS_QUIET) || (a == OFS_STATUS) ||
		         (a == OFS_IRQ_STAT) || (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN);
	endfunction : is_reg

	// ---------------- register file ----------------
	logic [3:0]       ctrl_reg, ctrl_next;          // cfg, plausibility, fault outputs
	logic [9:0]       quiet_reg, quiet_next;        // quiet interval in 10 ms steps
	logic [IRQ_W-1:0] ien_reg, ien_next;            // interrupt enables
	logic [IRQ_W-1:0] ist_reg, ist_next;            // sticky events
	logic [31:0]      rd_reg, rd_next;              // read data, loaded in setup phase
	logic [IRQ_W-1:0] events;                       // one-cycle event pulses
	logic             wr_acc;
	logic [4:0]       status;

	assign wr_acc = psel && penable && pwrite;

	// register next values; set beats clear on the sticky bits
	always_comb begin
		logic [9:0] q;
		q          = pwdata[9:0];
		ctrl_next  = ctrl_reg;
		quiet_next = quiet_reg;
		ien_next   = ien_reg;
		ist_next   = ist_reg;
		if (wr_acc) begin
			case (paddr)
				OFS_CTRL:    ctrl_next = pwdata[3:0];
				OFS_QUIET: begin
					// out-of-range values are clamped into the legal span
					if (q < QUIET_MIN_STEP) begin
						quiet_next = QUIET_MIN_STEP;
					end else if (q > QUIET_MAX_STEP) begin
						quiet_next = QUIET_MAX_STEP;
					end else begin
						quiet_next = q;
					end
				end
				OFS_IRQ_CLR: ist_next = ist_reg & ~pwdata[IRQ_W-1:0];
				OFS_IRQ_EN:  ien_next = pwdata[IRQ_W-1:0];
				default:     ;                                   // read-only or unmapped
			endcase
		end
		ist_next = ist_next | events;
		// read data captured in setup so it comes from a flop in access
		rd_next = rd_reg;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL:     rd_next = {28'h0000000, ctrl_reg};
				OFS_QUIET:    rd_next = {22'h000000, quiet_reg};
				OFS_STATUS:   rd_next = {27'h0000000, status};
				OFS_IRQ_STAT: rd_next = {29'h00000000, ist_reg};
				OFS_IRQ_EN:   rd_next = {29'h00000000, ien_reg};
				default:      rd_next = 32'h00000000;            // clear register reads zero
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= CTRL_RST;
			quiet_reg <= QUIET_RST_STEP;
			ien_reg   <= '0;
			ist_reg   <= '0;
			rd_reg    <= 32'h00000000;
		end else begin
			ctrl_reg  <= ctrl_next;
			quiet_reg <= quiet_next;
			ien_reg   <= ien_next;
			ist_reg   <= ist_next;
			rd_reg    <= rd_next;
		end
	end

	// zero-wait slave; unmapped offsets answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !is_reg(paddr);
	assign prdata  = rd_reg;

	// ---------------- evaluation ----------------
	logic [1:0]   cfg;
	logic [3:0]   mask;
	logic         plaus_en;
	logic         fout_en;
	sdt_state_t   st_reg, st_next;
	logic [3:0]   trk_reg, trk_next;        // track sample of the previous logic cycle
	logic         perm_reg, perm_next;      // permit sample of the previous logic cycle
	logic [15:0]  quiet_ms;                 // interval in ms
	logic [15:0]  el_reg, el_next;          // elapsed quiet time in ms
	logic [1:0]   low_reg, low_next;        // pair was both-low at the last cycle
	logic [1:0]   flt_reg, flt_next;        // pair faults
	logic [1:0]   pair_on;                  // pairs checked for plausibility
	logic         edge_seen;
	logic         ev_still;                 // standstill reached this tick
	logic [1:0]   flt_rise;                 // pair fault newly set

	assign cfg      = ctrl_reg[CTRL_CFG_LSB +: 2];
	assign mask     = trk_mask(cfg);
	assign plaus_en = ctrl_reg[CTRL_PLAUS_BIT];
	assign fout_en  = ctrl_reg[CTRL_FOUT_BIT];
	assign quiet_ms = 16'(quiet_reg * QUIET_STEP_MS);
	// a single-track setup has no pair, so no check runs even if enabled
	assign pair_on  = plaus_en ? {mask[3], mask[1]} : 2'b00;
	// only enabled tracks count as edges
	assign edge_seen = |((smp.trk ^ trk_reg) & mask);

	// state, quiet counter and samples step on the tick; a high permit resets state and counter on any clock
	always_comb begin
		st_next   = st_reg;
		el_next   = el_reg;
		trk_next  = trk_reg;
		perm_next = perm_reg;
		ev_still  = 1'b0;
		if (smp.permit) begin
			// running drive: any evaluation is dropped at once
			st_next = SDT_IDLE;
			el_next = '0;
		end
		if (smp.tick) begin
			trk_next  = smp.trk;
			perm_next = smp.permit;
			case (st_reg)
				SDT_IDLE: begin
					if (perm_reg && !smp.permit) begin
						st_next = SDT_EVAL;
						el_next = '0;
					end
				end
				SDT_EVAL: begin
					if (smp.permit) begin
						st_next = SDT_IDLE;
					end else if (edge_seen) begin
						el_next = '0;
					end else if (el_reg + 16'(LOGIC_CYCLE_MS) >= quiet_ms) begin
						st_next   = SDT_STILL;
						ev_still  = 1'b1;
					end else begin
						el_next = el_reg + 16'(LOGIC_CYCLE_MS);
					end
				end
				SDT_STILL: ;                         // edges no longer watched
				default: st_next = SDT_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg   <= SDT_IDLE;
			el_reg   <= '0;
			trk_reg  <= '0;
			perm_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			el_reg   <= el_next;
			trk_reg  <= trk_next;
			perm_reg <= perm_next;
		end
	end

	// ---------------- plausibility, one slice per pair ----------------
	for (genvar p = 0; p < 2; p++) begin : g_pair
		logic both_low;
		assign both_low = !smp.trk[2*p] && !smp.trk[2*p+1];

		// a single both-low cycle is tolerated; the second in a row trips
		always_comb begin
			low_next[p] = low_reg[p];
			flt_next[p] = flt_reg[p];
			if (!pair_on[p]) begin
				low_next[p] = 1'b0;
				flt_next[p] = 1'b0;
			end else if (smp.tick) begin
				low_next[p] = both_low;
				if (both_low && low_reg[p]) begin
					flt_next[p] = 1'b1;
				end else if (!both_low && !smp.permit) begin
					flt_next[p] = 1'b0;
				end
			end
		end
		assign flt_rise[p] = flt_next[p] && !flt_reg[p];
	end

	// one driver for the event vector, gathered from both sources
	assign events = {flt_rise, ev_still};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_reg <= '0;
			flt_reg <= '0;
		end else begin
			low_reg <= low_next;
			flt_reg <= flt_next;
		end
	end

	// ---------------- outputs ----------------
	// standstill follows the state flop, which permit already cleared
	assign standstill  = (st_reg == SDT_STILL);
	// absent fault outputs stay low; status still shows the raw faults
	assign pair1_fault = fout_en && flt_reg[0];
	assign pair2_fault = fout_en && flt_reg[1];
	assign group_fault = fout_en && |flt_reg;
	assign status      = {(st_reg == SDT_EVAL), |flt_reg, flt_reg, (st_reg == SDT_STILL)};
	assign irq         = |(ist_reg & ien_reg);
endmodule : sdt_top

// >>> tb/sdt_monitor.sv
module sdt_monitor #(
	parameter int unsigned CYCLE_CLKS = 20
) (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// pins
	input wire logic       motion_permit,
	input wire logic [3:0] enc_trk,
	input wire logic       standstill,
	input wire logic       pair1_fault,
	input wire logic       pair2_fault,
	input wire logic       group_fault
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned q_cnt;   // clocks since track 0 moved or permit high
	int unsigned lo1_cnt; // clocks with pair 1 both low
	int unsigned lo2_cnt; // clocks with pair 2 both low
	logic        trk0_q;  // last track 0 level
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// track 0 is watched in every configuration, so other tracks may not restart q_cnt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_cnt   <= 0;
			lo1_cnt <= 0;
			lo2_cnt <= 0;
			trk0_q  <= 1'h0;
		end else begin
			trk0_q  <= enc_trk[0];
			q_cnt   <= (motion_permit || enc_trk[0] != trk0_q) ? 0 : q_cnt + 1;
			lo1_cnt <= (enc_trk[1:0] == 2'h0) ? lo1_cnt + 1 : 0;
			lo2_cnt <= (enc_trk[3:2] == 2'h0) ? lo2_cnt + 1 : 0;
		end
	end
	// permit held past the synchroniser delay
	sequence s_permit_on;
		motion_permit [*8];
	endsequence
	sequence s_permit_off;
		!motion_permit [*8];
	endsequence
	a_permit_clears_still: assert property (s_permit_on |-> !standstill)
		else $error("standstill high with permit held");
	a_still_holds_on: assert property (s_permit_off ##0 standstill |=> standstill)
		else $error("standstill dropped with permit low");
	a_still_after_quiet: assert property ($rose(standstill) |-> q_cnt >= 24 * CYCLE_CLKS)
		else $error("standstill before quiet interval");
	a_group_is_or: assert property (group_fault == (pair1_fault || pair2_fault))
		else $error("group fault differs from pair faults");
	a_pair1_two_cycles: assert property ($rose(pair1_fault) |-> lo1_cnt >= CYCLE_CLKS)
		else $error("pair 1 fault too early");
	a_pair2_two_cycles: assert property ($rose(pair2_fault) |-> lo2_cnt >= CYCLE_CLKS)
		else $error("pair 2 fault too early");
	a_pair1_clear_cause: assert property ($fell(pair1_fault) |-> $past(lo1_cnt, 4) == 0 && !$past(motion_permit, 4))
		else $error("pair 1 fault cleared without cause");
	a_pair2_clear_cause: assert property ($fell(pair2_fault) |-> $past(lo2_cnt, 4) == 0 && !$past(motion_permit, 4))
		else $error("pair 2 fault cleared without cause");
endmodule : sdt_monitor

bind sdt_top sdt_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) sdt_monitor_i (.pclk(pclk), .presetn(presetn),
	.motion_permit(motion_permit), .enc_trk(enc_trk), .standstill(standstill), .pair1_fault(pair1_fault),
	.pair2_fault(pair2_fault), .group_fault(group_fault));

// >>> tb/sdt_enc_model.sv
module sdt_enc_model #(
	parameter int unsigned CYCLE_CLKS = 20
) (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// bench commands
	input  wire logic       permit_cmd,
	input  wire logic       spin,
	input  wire logic [3:0] lo_mask,
	// machine pins
	output logic            motion_permit,
	output logic      [3:0] enc_trk
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned div; // clocks in the current phase
	logic        ph;  // encoder phase
	// a phase lasts two logic cycles so no pulse slips between samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div           <= 0;
			ph            <= 1'h0;
			motion_permit <= 1'h0;
		end else begin
			motion_permit <= permit_cmd;
			if (spin) begin
				div <= (div == 2 * CYCLE_CLKS - 1) ? 0 : div + 1;
				ph  <= (div == 2 * CYCLE_CLKS - 1) ? ~ph : ph;
			end
		end
	end
	// complementary tracks: a cable break pulls both of a pair low
	assign enc_trk = {~ph, ph, ~ph, ph} & ~lo_mask;
endmodule : sdt_enc_model

// >>> tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sdt_pkg::*;
	localparam int unsigned C = 20; // short logic cycle, still 4 ms of counting
	typedef struct {string nm; logic [31:0] v;} sdt_exp_t;
	sdt_exp_t    q[$];             // expected results, oldest first
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, seed;
	logic        pready, pslverr, motion_permit, standstill, pair1_fault, pair2_fault, group_fault, irq;
	logic [3:0]  enc_trk, lo_mask = 4'h0;
	logic        permit_cmd = 1'h0, spin = 1'h0, smp = 1'h0;
	int          fails = 0, n_checks = 0, cyc = 0;
	always #50 pclk = ~pclk;
	sdt_top #(.CYCLE_CLKS(C)) sdt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.motion_permit(motion_permit), .enc_trk(enc_trk), .standstill(standstill), .pair1_fault(pair1_fault),
		.pair2_fault(pair2_fault), .group_fault(group_fault), .irq(irq));
	sdt_enc_model #(.CYCLE_CLKS(C)) sdt_enc_model_i (.pclk(pclk), .presetn(presetn), .permit_cmd(permit_cmd),
		.spin(spin), .lo_mask(lo_mask), .motion_permit(motion_permit), .enc_trk(enc_trk));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	// setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		q.push_back('{nm, e});
		apb(1'h0, a, 32'h0);
	endtask : rd
	// pins as {irq, group, pair2, pair1, standstill}
	task automatic pins(input logic [4:0] e, input string nm);
		q.push_back('{nm, {27'h0, e}});
		@(posedge pclk);
		smp <= 1'h1;
		@(posedge pclk);
		smp <= 1'h0;
	endtask : pins
	// compares each completed read or pin sample with the oldest note
	always @(posedge pclk) begin : watch
		sdt_exp_t e;
		// only the unmapped offset may answer with an error
		if (psel && penable && pready) check("pslverr", {31'h0, pslverr}, {31'h0, paddr == 8'h18});
		if ((psel && penable && pready && !pwrite) || smp) begin
			if (q.size() == 0) check("queue", 32'h1, 32'h0);
			else begin
				e = q.pop_front();
				check(e.nm, smp ? {27'h0, irq, group_fault, pair2_fault, pair1_fault, standstill} : prdata, e.v);
			end
		end
	end
	// hang guard: the whole run needs well under this
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 12000) begin
			fails++;
			results();
		end
	end
	initial begin
		int         t;
		logic [9:0] qs;
		seed = 32'h19444EBB;
		wt(20);
		presetn <= 1'h1;
		rd(OFS_CTRL, 32'h0, "ctrl reset");
		rd(OFS_QUIET, 32'h00A, "quiet reset");
		rd(8'h18, 32'h0, "unmapped");
		apb(1'h1, OFS_QUIET, 32'h5);
		rd(OFS_QUIET, 32'h00A, "quiet low clamp");
		apb(1'h1, OFS_QUIET, 32'h3FF);
		rd(OFS_QUIET, 32'h3E8, "quiet high clamp");
		seed = lfsr(seed);
		qs = 10'h00A + {6'h0, seed[3:0]};
		t = (qs * 10 + 3) / 4;
		apb(1'h1, OFS_QUIET, {22'h0, qs});
		apb(1'h1, OFS_CTRL, 32'hD);
		apb(1'h1, OFS_IRQ_EN, 32'h7);
		// turning while released, then still turning after the permit falls
		permit_cmd <= 1'h1;
		spin <= 1'h1;
		wt(3 * C);
		pins(5'h00, "running");
		permit_cmd <= 1'h0;
		wt(10 * C);
		spin <= 1'h0;
		wt((t - 3) * C);
		pins(5'h00, "quiet not yet");
		wt(5 * C);
		pins(5'h11, "standstill");
		spin <= 1'h1;
		wt(4 * C);
		pins(5'h11, "edges ignored");
		spin <= 1'h0;
		permit_cmd <= 1'h1;
		wt(8);
		pins(5'h10, "permit clears");
		apb(1'h1, OFS_IRQ_EN, 32'h0);
		pins(5'h00, "irq masked");
		apb(1'h1, OFS_IRQ_EN, 32'h7);
		rd(OFS_IRQ_STAT, 32'h1, "standstill event");
		apb(1'h1, OFS_IRQ_CLR, 32'h7);
		pins(5'h00, "irq cleared");
		// two pairs: a dip under one logic cycle passes, a longer one faults
		apb(1'h1, OFS_CTRL, 32'hE);
		lo_mask <= 4'h3;
		wt(C / 2);
		lo_mask <= 4'h0;
		wt(2 * C);
		pins(5'h00, "short dip");
		lo_mask <= 4'hF;
		wt(3 * C);
		pins(5'h1E, "both pair faults");
		lo_mask <= 4'h0;
		wt(3 * C);
		pins(5'h1E, "held while permit high");
		permit_cmd <= 1'h0;
		wt(2 * C);
		pins(5'h10, "faults cleared");
		// fault pins absent, one pair broken alone
		apb(1'h1, OFS_IRQ_CLR, 32'h7);
		apb(1'h1, OFS_CTRL, 32'h6);
		lo_mask <= 4'h3;
		wt(3 * C);
		pins(5'h10, "fault pins absent");
		rd(OFS_STATUS, 32'h1A, "pair one only");
		results();
	end
endmodule : tb
